// ---- common/gfc_pkg.sv ----
package gfc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0]  TICK_LAST     = 7'(TICK_CYCLES - 1);
  localparam logic [19:0] GATE_MIN_US   = 20'h00064;
  localparam logic [19:0] GATE_MAX_US   = 20'hF4240;
  localparam logic [19:0] GATE_RST_US   = 20'h186A0;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_GATE   = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_RESULT = 8'h0C;
  localparam logic [7:0] ADR_AUX    = 8'h10;

  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_FUNC_LSB = 1;
  localparam int unsigned CTRL_HOLD_BIT = 4;
  localparam int unsigned CTRL_DISP_BIT = 5;
  localparam int unsigned CTRL_ARM_BIT  = 8;

  localparam int unsigned STAT_VALID_BIT = 0;
  localparam int unsigned STAT_GATE_BIT  = 1;
  localparam int unsigned STAT_ARMED_BIT = 2;
  localparam int unsigned STAT_HELD_BIT  = 3;
  localparam int unsigned STAT_TOTAL_BIT = 4;
  localparam int unsigned STAT_OVER_BIT  = 5;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    FN_FREQ      = 3'b000,
    FN_PERIOD    = 3'b001,
    FN_PER_AVG   = 3'b010,
    FN_WIDTH     = 3'b011,
    FN_TOT_INF   = 3'b100,
    FN_TOT_GATED = 3'b101
  } gfc_func_e;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_ARMED = 3'b001,
    ST_MEAS  = 3'b010,
    ST_TOTAL = 3'b011,
    ST_HELD  = 3'b100
  } gfc_state_e;

  typedef struct packed {
    logic      disp_gate;
    logic      hold;
    gfc_func_e func;
    logic      enable;
  } gfc_ctrl_s;

  localparam gfc_ctrl_s CTRL_RST = '{disp_gate: 1'b0, hold: 1'b0, func: FN_FREQ, enable: 1'b0};

endpackage

// ---- verilog/gfc_sync.sv ----
module gfc_sync
  import gfc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      rise,
  output logic      fall
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic s1_next;
  logic s2_next;
  logic s3_next;

  // ****************************************
  // Two-stage synchroniser, third stage for edges
  // ****************************************
  always_comb begin
    s1_next = async_in;
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  assign rise = s2_reg & ~s3_reg;
  assign fall = ~s2_reg & s3_reg;

endmodule

// ---- verilog/gfc_top.sv ----
module gfc_top
  import gfc_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        MEASURED_SIGNAL_INPUT,
  output logic             WAVEGEN_HALT,
  output logic             RESULT_VALID
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    reg_hit = (adr[7:2] == off[7:2]);
  endfunction

  function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge_sel = res;
  endfunction

  function automatic logic [19:0] clamp_gate(input logic [31:0] v);
    if (v < {12'h000, GATE_MIN_US}) begin
      clamp_gate = GATE_MIN_US;
    end else if (v > {12'h000, GATE_MAX_US}) begin
      clamp_gate = GATE_MAX_US;
    end else begin
      clamp_gate = v[19:0];
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  gfc_ctrl_s   ctrl_reg,   ctrl_next;
  logic [19:0] gate_reg,   gate_next;
  gfc_state_e  state_reg,  state_next;
  logic [6:0]  pre_reg,    pre_next;
  logic [19:0] us_reg,     us_next;
  logic [31:0] cyc_reg,    cyc_next;
  logic [31:0] edge_reg,   edge_next;
  logic [31:0] last_reg,   last_next;
  logic [31:0] result_reg, result_next;
  logic [31:0] aux_reg,    aux_next;
  logic        valid_reg,  valid_next;
  logic        over_reg,   over_next;
  logic        ack_reg,    ack_next;
  logic [31:0] dat_reg,    dat_next;

  logic        in_rise;
  logic        in_fall;
  logic        wr;
  logic        rd;
  logic        arm;
  logic        tick;
  logic        gate_end;
  logic        finish;
  logic [31:0] fin_val;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_wr;
  logic [31:0] status_word;

  gfc_sync u_sync (
    .clk      (REF_CLK),
    .rst_b    (RST_B),
    .async_in (MEASURED_SIGNAL_INPUT),
    .rise     (in_rise),
    .fall     (in_fall)
  );

  // ****************************************
  // Wishbone slave and registers
  // ****************************************
  assign wr  = WB_CYC_I & WB_STB_I & WB_WE_I & ~ack_reg;
  assign rd  = WB_CYC_I & WB_STB_I & ~WB_WE_I & ~ack_reg;
  assign arm = wr & reg_hit(WB_ADR_I, ADR_CTRL) & WB_SEL_I[1] & WB_DAT_I[CTRL_ARM_BIT];

  assign ctrl_word = {26'h0, ctrl_reg};
  assign ctrl_wr   = merge_sel(ctrl_word, WB_DAT_I, WB_SEL_I);

  always_comb begin
    status_word                 = 32'h0;
    status_word[STAT_VALID_BIT] = valid_reg;
    status_word[STAT_GATE_BIT]  = (state_reg == ST_MEAS);
    status_word[STAT_ARMED_BIT] = (state_reg == ST_ARMED);
    status_word[STAT_HELD_BIT]  = (state_reg == ST_HELD);
    status_word[STAT_TOTAL_BIT] = (state_reg == ST_TOTAL);
    status_word[STAT_OVER_BIT]  = over_reg;
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    gate_next = gate_reg;
    ack_next  = WB_CYC_I & WB_STB_I & ~ack_reg;
    dat_next  = 32'h0;
    if (wr && reg_hit(WB_ADR_I, ADR_CTRL)) begin
      ctrl_next.enable    = ctrl_wr[CTRL_EN_BIT];
      ctrl_next.func      = gfc_func_e'(ctrl_wr[CTRL_FUNC_LSB +: 3]);
      ctrl_next.hold      = ctrl_wr[CTRL_HOLD_BIT];
      ctrl_next.disp_gate = ctrl_wr[CTRL_DISP_BIT];
      if (ctrl_wr[CTRL_FUNC_LSB +: 3] > FN_TOT_GATED) begin
        ctrl_next.func = ctrl_reg.func;
      end
    end
    if (wr && reg_hit(WB_ADR_I, ADR_GATE)) begin
      gate_next = clamp_gate(merge_sel({12'h0, gate_reg}, WB_DAT_I, WB_SEL_I));
    end
    if (rd) begin
      if (reg_hit(WB_ADR_I, ADR_CTRL)) begin
        dat_next = ctrl_word;
      end else if (reg_hit(WB_ADR_I, ADR_GATE)) begin
        dat_next = {12'h0, gate_reg};
      end else if (reg_hit(WB_ADR_I, ADR_STATUS)) begin
        dat_next = status_word;
      end else if (reg_hit(WB_ADR_I, ADR_RESULT)) begin
        dat_next = ctrl_reg.disp_gate ? {12'h0, gate_reg} : result_reg;
      end else if (reg_hit(WB_ADR_I, ADR_AUX)) begin
        dat_next = aux_reg;
      end
    end
  end

  // ****************************************
  // Measurement sequencer
  // ****************************************
  assign tick     = (pre_reg == TICK_LAST);
  assign gate_end = tick & (us_reg == gate_reg - 20'h1);

  always_comb begin
    finish  = 1'b0;
    fin_val = 32'h0;
    unique case (ctrl_reg.func)
      FN_FREQ, FN_TOT_GATED: begin
        finish  = gate_end;
        fin_val = edge_reg + {31'h0, in_rise};
      end
      FN_PERIOD: begin
        finish  = in_rise | gate_end;
        fin_val = in_rise ? cyc_reg + 32'h1 : 32'h0;
      end
      FN_WIDTH: begin
        finish  = in_fall | gate_end;
        fin_val = in_fall ? cyc_reg + 32'h1 : 32'h0;
      end
      FN_PER_AVG: begin
        finish  = gate_end;
        fin_val = in_rise ? cyc_reg + 32'h1 : last_reg;
      end
      FN_TOT_INF: begin
        finish  = 1'b0;
        fin_val = 32'h0;
      end
      default: begin
        finish  = 1'b0;
        fin_val = 32'h0;
      end
    endcase
  end

  always_comb begin
    state_next  = state_reg;
    pre_next    = pre_reg;
    us_next     = us_reg;
    cyc_next    = cyc_reg;
    edge_next   = edge_reg;
    last_next   = last_reg;
    result_next = result_reg;
    aux_next    = aux_reg;
    valid_next  = valid_reg;
    over_next   = over_reg;
    if (rd && reg_hit(WB_ADR_I, ADR_RESULT)) begin
      valid_next = 1'b0;
    end
    if (!ctrl_next.enable) begin
      state_next = ST_OFF;
    end else if (arm || state_reg == ST_OFF) begin
      state_next  = ST_ARMED;
      result_next = 32'h0;
      aux_next    = 32'h0;
      valid_next  = 1'b0;
      over_next   = 1'b0;
    end else begin
      unique case (state_reg)
        ST_ARMED: begin
          if (in_rise) begin
            pre_next  = 7'h00;
            us_next   = 20'h0;
            cyc_next  = 32'h0;
            edge_next = 32'h0;
            last_next = 32'h0;
            if (ctrl_reg.func == FN_TOT_INF) begin
              state_next  = ST_TOTAL;
              result_next = 32'h1;
              valid_next  = 1'b1;
            end else begin
              state_next = ST_MEAS;
            end
          end
        end
        ST_MEAS: begin
          pre_next = tick ? 7'h00 : pre_reg + 7'h1;
          us_next  = tick ? us_reg + 20'h1 : us_reg;
          cyc_next = cyc_reg + 32'h1;
          if (in_rise) begin
            edge_next = edge_reg + 32'h1;
            last_next = cyc_reg + 32'h1;
          end
          if (finish) begin
            result_next = fin_val;
            aux_next    = edge_reg + {31'h0, in_rise};
            over_next   = gate_end & ~in_rise & ~in_fall;
            valid_next  = 1'b1;
            state_next  = ctrl_reg.hold ? ST_HELD : ST_ARMED;
          end
        end
        ST_TOTAL: begin
          if (in_rise) begin
            result_next = result_reg + 32'h1;
            valid_next  = 1'b1;
          end
        end
        ST_HELD: begin
          state_next = ST_HELD;
        end
        ST_OFF: begin
          state_next = ST_ARMED;
        end
        default: begin
          state_next = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_reg   <= CTRL_RST;
      gate_reg   <= GATE_RST_US;
      state_reg  <= ST_OFF;
      pre_reg    <= 7'h00;
      us_reg     <= 20'h0;
      cyc_reg    <= 32'h0;
      edge_reg   <= 32'h0;
      last_reg   <= 32'h0;
      result_reg <= 32'h0;
      aux_reg    <= 32'h0;
      valid_reg  <= 1'b0;
      over_reg   <= 1'b0;
      ack_reg    <= 1'b0;
      dat_reg    <= 32'h0;
    end else begin
      ctrl_reg   <= ctrl_next;
      gate_reg   <= gate_next;
      state_reg  <= state_next;
      pre_reg    <= pre_next;
      us_reg     <= us_next;
      cyc_reg    <= cyc_next;
      edge_reg   <= edge_next;
      last_reg   <= last_next;
      result_reg <= result_next;
      aux_reg    <= aux_next;
      valid_reg  <= valid_next;
      over_reg   <= over_next;
      ack_reg    <= ack_next;
      dat_reg    <= dat_next;
    end
  end

  assign WB_DAT_O     = dat_reg;
  assign WB_ACK_O     = ack_reg;
  assign WAVEGEN_HALT = ctrl_reg.enable;
  assign RESULT_VALID = valid_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  sequence seq_rd_result;
    rd && reg_hit(WB_ADR_I, ADR_RESULT) && ctrl_reg.disp_gate;
  endsequence

  sequence seq_meas_done;
    state_reg == ST_MEAS && ctrl_next.enable && !arm && finish;
  endsequence

  AST_FUNC_LEGAL: assert property (ctrl_reg.func <= FN_TOT_GATED)
    else $error("illegal measurement function held");
  AST_TOTAL_STEP: assert property (state_reg == ST_TOTAL && in_rise && !arm && ctrl_next.enable
    |=> result_reg == $past(result_reg) + 32'h1)
    else $error("unbounded totalize missed a pulse");
  AST_GATE_BOUND: assert property (state_reg == ST_MEAS |-> us_reg < gate_reg)
    else $error("gate stayed open past gate time");
  AST_CONT_REARM: assert property (seq_meas_done ##0 !ctrl_reg.hold |=> state_reg == ST_ARMED)
    else $error("continuous mode did not re-arm");
  AST_HOLD_FREEZE: assert property (state_reg == ST_HELD && !arm && ctrl_next.enable
    |=> $stable(result_reg) && state_reg == ST_HELD)
    else $error("held result changed");
  AST_GATE_RANGE: assert property (gate_reg >= GATE_MIN_US && gate_reg <= GATE_MAX_US)
    else $error("gate time outside allowed span");
  AST_DISP_GATE: assert property (seq_rd_result |=> WB_DAT_O == {12'h0, $past(gate_reg)})
    else $error("display select ignored");
  AST_EDGE_ONLY: assert property (state_reg == ST_MEAS && !in_rise && !finish && !arm
    && ctrl_next.enable |=> $stable(edge_reg))
    else $error("edge count moved without input edge");
  AST_ARM_CLEARS: assert property (arm && ctrl_next.enable
    |=> state_reg == ST_ARMED && result_reg == 32'h0 && !RESULT_VALID)
    else $error("reset/arm did not clear and arm");
  AST_HALT_FOLLOWS: assert property (wr && reg_hit(WB_ADR_I, ADR_CTRL) && WB_SEL_I[0]
    |=> WAVEGEN_HALT == $past(WB_DAT_I[CTRL_EN_BIT]))
    else $error("halt output does not follow enable");
  AST_VALID_SET: assert property (seq_meas_done |=> RESULT_VALID ##0 result_reg == $past(fin_val))
    else $error("result valid not raised at completion");
  AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");

endmodule

// ---- tb/gfc_src.sv ----
module gfc_src (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [15:0] hi_cyc,
  input  wire logic [15:0] lo_cyc,
  input  wire logic [15:0] pulses,
  output logic             sig
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] ph;
  logic [15:0] done;

  // Low phase then high phase; a finite burst ends and stays low
  always_ff @(posedge clk) begin
    if (!run) begin
      ph <= 16'h0000;
      done <= 16'h0000;
      sig <= 1'b0;
    end else if (pulses != 16'h0000 && done == pulses) begin
      sig <= 1'b0;
    end else if (ph == lo_cyc + hi_cyc - 16'h0001) begin
      ph <= 16'h0000;
      done <= done + 16'h0001;
      sig <= 1'b0;
    end else begin
      ph <= ph + 16'h0001;
      sig <= (ph + 16'h0001 >= lo_cyc);
    end
  end
endmodule

// ---- tb/gated_frequency_counter_bench.sv ----
module gated_frequency_counter_bench
  import gfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    gfc_func_e   func;
    logic [15:0] hi;
    logic [15:0] lo;
    logic [31:0] res;
    logic [31:0] aux;
    logic        aux_on;
  } gfc_row_s;

  // Gate of 100 us is 10000 cycles; edge counts stay clear of the gate boundary
  localparam gfc_row_s ROWS [5] = '{
    '{FN_FREQ,      16'h0032, 16'h0046, 32'h00000053, 32'h00000053, 1'b1},
    '{FN_PERIOD,    16'h0032, 16'h0046, 32'h00000078, 32'h00000000, 1'b0},
    '{FN_PER_AVG,   16'h0032, 16'h0046, 32'h000026E8, 32'h00000053, 1'b1},
    '{FN_WIDTH,     16'h0032, 16'h0046, 32'h00000032, 32'h00000000, 1'b0},
    '{FN_TOT_GATED, 16'h001E, 16'h0028, 32'h0000008E, 32'h0000008E, 1'b1}
  };

  logic        clk;
  logic        rst_b;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        halt;
  logic        valid;
  logic        sig;
  logic        run;
  logic [15:0] hi;
  logic [15:0] lo;
  logic [15:0] npls;
  logic [31:0] q;
  int          mismatches;
  int          comparisons;

  gfc_top DUT (.REF_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .MEASURED_SIGNAL_INPUT(sig), .WAVEGEN_HALT(halt), .RESULT_VALID(valid));

  gfc_src src (.clk(clk), .run(run), .hi_cyc(hi), .lo_cyc(lo), .pulses(npls), .sig(sig));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************
  // Bus cycle
  // ****************************************
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (w) chk(rdat, 32'h00000000);
    @(posedge clk);
    chk({31'h0, ack}, 32'h00000000);
  endtask

  task automatic wait_valid();
    int n;
    n = 0;
    while (valid !== 1'b1 && n < 15000) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, valid}, 32'h00000001);
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial begin
    {rst_b, cyc, stb, we, run} <= 5'h00;
    {adr, sel, wdat, hi, lo, npls} <= '0;
    repeat (12) @(posedge clk);
    chk({29'h0, valid, halt, ack}, 32'h00000000);
    chk(rdat, 32'h00000000);
    rst_b <= 1'b1;
    wb(1'b0, ADR_CTRL, 4'hF, 32'h0);
    chk(q, 32'h00000000);
    wb(1'b0, ADR_GATE, 4'hF, 32'h0);
    chk(q, 32'h000186A0);
    // ****************************************
    // Registers, clamping, unmapped place
    // ****************************************
    wb(1'b1, ADR_GATE, 4'h1, 32'hFFFFFFC8);
    wb(1'b0, ADR_GATE, 4'hF, 32'h0);
    chk(q, 32'h000186C8);
    wb(1'b1, ADR_GATE, 4'hF, 32'h0);
    wb(1'b0, ADR_GATE, 4'hF, 32'h0);
    chk(q, 32'h00000064);
    wb(1'b1, ADR_GATE, 4'hF, 32'h000FFFFF);
    wb(1'b0, ADR_GATE, 4'hF, 32'h0);
    chk(q, 32'h000F4240);
    wb(1'b1, ADR_GATE, 4'hF, 32'h00000064);
    wb(1'b1, ADR_CTRL, 4'hF, 32'h00000002);
    wb(1'b1, ADR_CTRL, 4'hF, 32'h0000000E);
    wb(1'b0, ADR_CTRL, 4'hF, 32'h0);
    chk(q, 32'h00000002);
    wb(1'b1, ADR_CTRL, 4'hF, 32'h00000020);
    wb(1'b0, ADR_RESULT, 4'hF, 32'h0);
    chk(q, 32'h00000064);
    wb(1'b1, 8'h14, 4'hF, 32'h00000005);
    wb(1'b0, 8'h14, 4'hF, 32'h0);
    chk(q, 32'h00000000);
    // ****************************************
    // Table of measurement functions, hold mode
    // ****************************************
    foreach (ROWS[i]) begin
      run <= 1'b0;
      hi <= ROWS[i].hi;
      lo <= ROWS[i].lo;
      wb(1'b1, ADR_CTRL, 4'hF, 32'h0);
      run <= 1'b1;
      wb(1'b1, ADR_CTRL, 4'hF, {27'h0, 1'b1, ROWS[i].func, 1'b1});
      chk({31'h0, halt}, 32'h00000001);
      wait_valid();
      wb(1'b0, ADR_RESULT, 4'hF, 32'h0);
      chk(q, ROWS[i].res);
      if (ROWS[i].aux_on) begin
        wb(1'b0, ADR_AUX, 4'hF, 32'h0);
        chk(q, ROWS[i].aux);
      end
    end
    chk({31'h0, valid}, 32'h00000000);
    repeat (11000) @(posedge clk);
    chk({31'h0, valid}, 32'h00000000);
    wb(1'b0, ADR_RESULT, 4'hF, 32'h0);
    chk(q, 32'h0000008E);
    wb(1'b0, ADR_STATUS, 4'hF, 32'h0);
    chk(q & 32'h00000008, 32'h00000008);
    // ****************************************
    // Arm in hold, then continuous repeat
    // ****************************************
    wb(1'b1, ADR_CTRL, 4'hF, 32'h00000113);
    wait_valid();
    wb(1'b0, ADR_RESULT, 4'hF, 32'h0);
    chk(q, 32'h00000046);
    wb(1'b0, ADR_CTRL, 4'hF, 32'h0);
    chk(q, 32'h00000013);
    wb(1'b1, ADR_CTRL, 4'hF, 32'h00000103);
    repeat (2) begin
      wait_valid();
      wb(1'b0, ADR_RESULT, 4'hF, 32'h0);
      chk(q, 32'h00000046);
    end
    // ****************************************
    // Unbounded totalize on a burst of five
    // ****************************************
    run <= 1'b0;
    npls <= 16'h0005;
    wb(1'b1, ADR_CTRL, 4'hF, 32'h00000109);
    run <= 1'b1;
    repeat (600) @(posedge clk);
    wb(1'b0, ADR_RESULT, 4'hF, 32'h0);
    chk(q, 32'h00000005);
    wb(1'b0, ADR_STATUS, 4'hF, 32'h0);
    chk(q & 32'h00000010, 32'h00000010);
    wb(1'b1, ADR_CTRL, 4'hF, 32'h0);
    chk({31'h0, halt}, 32'h00000000);
    // ****************************************
    // Reset in mid-run
    // ****************************************
    wb(1'b1, ADR_CTRL, 4'hF, 32'h00000001);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk({29'h0, valid, halt, ack}, 32'h00000000);
    rst_b <= 1'b1;
    wb(1'b0, ADR_GATE, 4'hF, 32'h0);
    chk(q, 32'h000186A0);
    stop_test();
  end
endmodule
